//--- instr_memory_model.sv
// Instruction memory answering vector and byte reads of the core
`timescale 1ns/1ps
module instr_memory_model #(
   parameter logic [15:0] VECTOR_VALUE = 16'hE000
) (
   input  wire logic        i_clock,
   input  wire logic        i_vector_fetch,
   input  wire logic        i_check_read,
   input  wire logic [15:0] i_address,
   output logic      [15:0] o_vector_data,
   output logic      [7:0]  o_read_byte
);
   logic [15:0] junk_q = 16'h1234;
   // Idle cycles show a moving pattern, never the last answer
   always @(posedge i_clock) begin
      junk_q <= {junk_q[14:0], ~junk_q[15]};
   end
   // Substitute vector only in its strobe cycle
   assign o_vector_data = i_vector_fetch ? VECTOR_VALUE : junk_q;
   // Even addresses hold the debug-entry opcode
   assign o_read_byte = !i_check_read ? junk_q[7:0] :
                        (i_address[0] ? 8'h3C : 8'h00);
endmodule

//--- signed_branch_and_debug_entry.sv
// Execution of the signed branch and the debug-entry instruction
`timescale 1ns/1ps
module signed_branch_and_debug_entry #(
   parameter logic [15:0] VECTOR_ADDR = 16'hFFF0
) (
   input  wire logic                                           i_clock,
   input  wire logic                                           i_reset_n,
   input  wire logic                                           i_instr_valid,
   input  wire logic [7:0]                                     i_opcode,
   input  wire logic [7:0]                                     i_relative_offset_byte,
   input  wire logic [signed_branch_and_debug_entry_pkg::ADDR_W-1:0] i_pc,
   input  wire logic                                           i_negative_flag,
   input  wire logic                                           i_overflow_flag,
   input  wire logic                                           i_debug_request,
   input  wire logic                                           i_debug_enable,
   input  wire logic                                           i_debug_exit,
   input  wire logic [15:0]                                    i_vector_data,
   input  wire logic [7:0]                                     i_mem_rdata,
   output logic                                                o_busy,
   output logic                                                o_program_fetch,
   output logic                                                o_vector_fetch,
   output logic                                                o_check_read,
   output logic [signed_branch_and_debug_entry_pkg::ADDR_W-1:0] o_fetch_address,
   output logic                                                o_pc_load,
   output logic [signed_branch_and_debug_entry_pkg::ADDR_W-1:0] o_new_pc,
   output logic [signed_branch_and_debug_entry_pkg::ADDR_W-1:0] o_saved_return_pointer,
   output logic                                                o_debug_rom_active,
   output logic                                                o_debug_mode_active,
   output logic                                                o_done
);
   import signed_branch_and_debug_entry_pkg::*;

   // ==========================================================
   // Decode
   exec_state_t   state_q;
   exec_state_t   state_d;
   logic [1:0]    count_q;
   logic [1:0]    count_d;
   logic [15:0]   addr_q;
   logic [15:0]   addr_d;
   logic [15:0]   srp_q;
   logic [15:0]   srp_d;
   logic [15:0]   resume_q;
   logic          coincide_q;
   logic          rom_q;
   logic          rom_d;
   logic          active_q;
   logic          active_d;
   logic          pc_load_q;
   logic [15:0]   new_pc_q;
   logic          done_q;

   wire idle        = (state_q == S_IDLE);
   wire is_branch   = i_instr_valid && (i_opcode == OPC_BRANCH_GE);
   wire is_enter    = i_instr_valid && (i_opcode == OPC_ENTER_DEBUG);
   wire entry_go    = idle && (i_debug_request || is_enter);
   wire branch_go   = idle && is_branch && !i_debug_request;
   wire coincide    = i_debug_request && is_enter;
   wire ge_taken    = ~(i_negative_flag ^ i_overflow_flag); // RL1 RL2
   wire [15:0] sext = {{8{i_relative_offset_byte[7]}},
                       i_relative_offset_byte};
   wire [15:0] target = 16'(i_pc + BRANCH_PC_STEP + sext); // RL1
   wire [15:0] fall_through = 16'(i_pc + BRANCH_PC_STEP);
   wire last_fetch  = (count_q == LAST_FETCH);
   wire zero_byte   = (i_mem_rdata == OPC_ENTER_DEBUG);
   wire leave_debug = !i_debug_enable || i_debug_exit; // RL12 RL14
   wire [15:0] resume_addr = coincide_q ? resume_q : srp_q; // RL10
   wire fetch_next  = (state_d == S_BR_FETCH) ||
                      (state_d == S_DBG_FETCH) ||
                      (state_d == S_EXIT_FETCH);

   // ==========================================================
   // Sequencer
   always_comb begin
      state_d  = state_q;
      count_d  = count_q;
      addr_d   = addr_q;
      srp_d    = srp_q;
      rom_d    = rom_q;
      active_d = active_q;
      unique case (state_q)
         S_IDLE: begin
            if (entry_go) begin
               state_d = S_VECTOR;
               srp_d   = i_pc;                                   // RL5 RL9
               rom_d   = 1'b1;                                   // RL6
               addr_d  = VECTOR_ADDR;                            // RL4 RL7
            end else if (branch_go) begin
               state_d = S_BR_FETCH;
               count_d = ge_taken ? TAKEN_FETCHES : UNTAKEN_FETCHES; // RL3
               addr_d  = ge_taken ? target : fall_through;
            end
         end
         S_BR_FETCH, S_DBG_FETCH, S_EXIT_FETCH: begin
            count_d = 2'(count_q - COUNT_ONE);
            addr_d  = 16'(addr_q + FETCH_STEP);
            if (last_fetch) begin
               count_d = COUNT_ZERO;
               if (state_q == S_DBG_FETCH) begin
                  state_d = S_CHECK;
                  addr_d  = srp_q;
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         S_VECTOR: begin
            state_d = S_DBG_FETCH;                               // RL15
            count_d = DEBUG_FETCHES;
            addr_d  = i_vector_data;                             // RL7
         end
         S_CHECK: begin
            state_d  = S_ACTIVE;
            active_d = 1'b1;                                     // RL11
            if (zero_byte) begin
               srp_d = 16'(srp_q + POINTER_STEP);                // RL8
            end
         end
         S_ACTIVE: begin
            if (leave_debug) begin                               // RL12 RL14
               state_d  = S_EXIT_FETCH;
               count_d  = DEBUG_FETCHES;
               addr_d   = resume_addr;                           // RL13
               rom_d    = 1'b0;                                  // RL13
               active_d = 1'b0;
            end
         end
      endcase
   end

   // ==========================================================
   // State registers
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         state_q  <= S_IDLE;
         count_q  <= COUNT_ZERO;
         addr_q   <= RESET_ADDR;
         srp_q    <= RESET_ADDR;
         rom_q    <= 1'b0;
         active_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         count_q  <= count_d;
         addr_q   <= addr_d;
         srp_q    <= srp_d;
         rom_q    <= rom_d;
         active_q <= active_d;
      end
   end

   // Resume address captured on every entry, flagged when a debug request meets a debug-entry opcode
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         resume_q   <= RESET_ADDR;
         coincide_q <= 1'b0;
      end else if (entry_go) begin
         resume_q   <= i_pc;                                     // RL10
         coincide_q <= coincide;
      end
   end

   // ==========================================================
   // Strobes to fetch unit and program counter
   logic fetch_q;
   logic vector_q;
   logic check_q;
   logic busy_q;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         fetch_q   <= 1'b0;
         vector_q  <= 1'b0;
         check_q   <= 1'b0;
         busy_q    <= 1'b0;
         pc_load_q <= 1'b0;
         new_pc_q  <= RESET_ADDR;
         done_q    <= 1'b0;
      end else begin
         fetch_q   <= fetch_next;                                // RL3
         vector_q  <= (state_d == S_VECTOR);
         check_q   <= (state_d == S_CHECK);
         busy_q    <= (state_d != S_IDLE);
         pc_load_q <= (branch_go && ge_taken) ||
                      (state_q == S_ACTIVE && leave_debug);
         new_pc_q  <= (state_q == S_ACTIVE) ? resume_addr : target;
         done_q    <= (state_q != S_IDLE) && (state_d == S_IDLE);
      end
   end

   // Condition bits are never written by this block
   assign o_program_fetch        = fetch_q;                      // RL15
   assign o_vector_fetch         = vector_q;
   assign o_check_read           = check_q;
   assign o_busy                 = busy_q;
   assign o_fetch_address        = addr_q;
   assign o_pc_load              = pc_load_q;
   assign o_new_pc               = new_pc_q;
   assign o_saved_return_pointer = srp_q;
   assign o_debug_rom_active     = rom_q;
   assign o_debug_mode_active    = active_q;
   assign o_done                 = done_q;

   // ==========================================================
   // Assertions
   logic [3:0] fetch_run_q;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         fetch_run_q <= 4'h0;
      end else if (o_program_fetch) begin
         fetch_run_q <= 4'(fetch_run_q + 4'h1);
      end else begin
         fetch_run_q <= 4'h0;
      end
   end

   branch_target_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL1
      branch_go && ge_taken |=> o_pc_load && o_new_pc == $past(target)
         && o_fetch_address == $past(target))
      else $error("taken branch target wrong");

   signed_test_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL2
      branch_go && (i_negative_flag != i_overflow_flag) |=> !o_pc_load
         && o_fetch_address == $past(fall_through))
      else $error("signed less-than branch was taken");

   taken_refill_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL3
      branch_go && ge_taken |=> o_program_fetch [*3] ##1 !o_program_fetch)
      else $error("taken branch not three fetches");

   untaken_refill_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL3
      branch_go && !ge_taken |=> o_program_fetch ##1 !o_program_fetch)
      else $error("untaken branch not one fetch");

   pointer_save_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL5
      entry_go |=> o_saved_return_pointer == $past(i_pc) && o_debug_rom_active)
      else $error("return pointer not saved on entry");

   vector_seq_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL15
      entry_go |=> o_vector_fetch && o_fetch_address == VECTOR_ADDR
         ##1 o_program_fetch [*3] ##1 o_check_read)
      else $error("entry not vector then three fetches");

   pointer_bump_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL8
      state_q == S_CHECK && zero_byte |=>
         o_saved_return_pointer == 16'($past(srp_q) + POINTER_STEP))
      else $error("pointer not incremented on zero byte");

   disabled_return_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL14
      state_q == S_ACTIVE && !i_debug_enable |=> !o_debug_rom_active
         && o_fetch_address == $past(resume_addr))
      else $error("disabled debug did not return");

   stay_active_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL12
      state_q == S_ACTIVE && i_debug_enable && !i_debug_exit |=>
         o_debug_mode_active && o_debug_rom_active)
      else $error("debug mode left without exit command");

   coincide_resume_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL10
      state_q == S_ACTIVE && leave_debug && coincide_q |=>
         o_new_pc == resume_q)
      else $error("coincident entry resumes at wrong address");

   fetch_run_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // RL13
      fetch_run_q <= 4'h3)
      else $error("fetch burst longer than three");

   exit_refill_a: assert property ( // RL13
      @(posedge i_clock) disable iff (!i_reset_n)
      state_q == S_ACTIVE && leave_debug |=>
         (o_pc_load && o_new_pc == $past(resume_addr))
         ##0 o_program_fetch [*3] ##1 o_done)
      else $error("exit refill not three fetches then done");

   vector_pulse_a: assert property ( // RL7
      @(posedge i_clock) disable iff (!i_reset_n)
      o_vector_fetch |=> !o_vector_fetch && o_program_fetch
         && o_fetch_address == $past(i_vector_data))
      else $error("substitute vector not followed");

   check_addr_a: assert property ( // RL8
      @(posedge i_clock) disable iff (!i_reset_n)
      o_check_read |-> o_fetch_address == o_saved_return_pointer)
      else $error("check read not at saved pointer");

   rom_during_a: assert property ( // RL6
      @(posedge i_clock) disable iff (!i_reset_n)
      o_debug_mode_active |-> o_debug_rom_active)
      else $error("debug mode without debug rom");

   done_pulse_a: assert property ( // RL3
      @(posedge i_clock) disable iff (!i_reset_n)
      o_done |-> !o_busy ##1 !o_done)
      else $error("done not a single idle pulse");

   accept_busy_a: assert property ( // RL4
      @(posedge i_clock) disable iff (!i_reset_n)
      (branch_go || entry_go) |=> o_busy && !o_done)
      else $error("accepted request did not raise busy");

   taken_c: cover property (@(posedge i_clock) disable iff (!i_reset_n)
      branch_go && ge_taken);
   bump_c: cover property (@(posedge i_clock) disable iff (!i_reset_n)
      state_q == S_CHECK && zero_byte);
   exit_c: cover property (@(posedge i_clock) disable iff (!i_reset_n)
      state_q == S_ACTIVE && i_debug_enable && i_debug_exit);
   coincide_c: cover property (@(posedge i_clock) disable iff (!i_reset_n)
      entry_go && coincide);
   disabled_c: cover property (@(posedge i_clock) disable iff (!i_reset_n)
      state_q == S_ACTIVE && !i_debug_enable);

endmodule

//--- signed_branch_and_debug_entry_pkg.sv
// Constants for the signed branch and debug entry execution block
// Operation
// RL1: The signed greater-or-equal branch (2C) is taken when negative xor overflow is zero, to PC plus 2 plus the sign-extended offset.
// RL2: After a signed compare the branch is taken exactly when the register operand is at least the memory operand.
// RL3: A taken branch spends three program fetches refilling the queue, an untaken one a single fetch.
// RL4: The debug-entry instruction (00) acts like a software interrupt but stacks no registers.
// RL5: Debug entry first copies the program counter into the hidden saved return pointer.
// RL6: After saving the pointer the debug ROM and register block become active.
// RL7: A substitute vector is fetched at the software-interrupt vector address and execution continues there.
// RL8: The byte at the saved pointer is read and, if it is 00, the saved pointer is incremented.
// RL9: Every other cause of debug entry runs the same sequence with the pointer already at the next instruction.
// RL10: When entry is triggered just as a debug-entry instruction starts, the increment does not move the resume address.
// RL11: While debug mode is active the core runs commands that an outside host supplies over a serial wire.
// RL12: Debug mode ends only when a specific exit command is executed by the host's request.
// RL13: On exit the ROM and registers are disabled and the queue refills from the saved pointer.
// RL14: Debug mode is disabled by default and then the entry sequence returns straight to the user program.
// RL15: Debug entry takes one vector fetch then three program fetches, and the branch changes no condition bit.
package signed_branch_and_debug_entry_pkg;

   localparam int          ADDR_W            = 16;
   localparam logic [7:0]  OPC_BRANCH_GE     = 8'h2C;
   localparam logic [7:0]  OPC_ENTER_DEBUG   = 8'h00;
   localparam logic [15:0] BRANCH_PC_STEP    = 16'h0002;
   localparam logic [15:0] FETCH_STEP        = 16'h0002;
   localparam logic [15:0] POINTER_STEP      = 16'h0001;
   localparam logic [15:0] RESET_ADDR        = 16'h0000;
   localparam logic [15:0] VECTOR_ADDR_DFLT  = 16'hFFF0;
   localparam logic [1:0]  TAKEN_FETCHES     = 2'h3;
   localparam logic [1:0]  UNTAKEN_FETCHES   = 2'h1;
   localparam logic [1:0]  DEBUG_FETCHES     = 2'h3;
   localparam logic [1:0]  LAST_FETCH        = 2'h1;
   localparam logic [1:0]  COUNT_ONE         = 2'h1;
   localparam logic [1:0]  COUNT_ZERO        = 2'h0;

   typedef enum logic [6:0] {
      S_IDLE       = 7'h01,
      S_BR_FETCH   = 7'h02,
      S_VECTOR     = 7'h04,
      S_DBG_FETCH  = 7'h08,
      S_CHECK      = 7'h10,
      S_ACTIVE     = 7'h20,
      S_EXIT_FETCH = 7'h40
   } exec_state_t;

endpackage

//--- signed_branch_and_debug_entry_tb.sv
// Self-checking bench for the signed branch and debug entry block
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("wrong value %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module signed_branch_and_debug_entry_tb;
   import signed_branch_and_debug_entry_pkg::*;
   localparam logic [15:0] VEC_ADDR  = 16'hFFF6;
   localparam logic [15:0] VEC_VALUE = 16'hE000;
   typedef struct {
      logic [7:0]  r, m, off;
      logic [15:0] pc, exp_addr;
      logic        taken;
   } branch_row_t;
   typedef struct {
      logic [15:0] pc, exp_srp, exp_resume;
      logic        instr, req, en;
   } debug_row_t;
   branch_row_t br_rows[6] = '{
      '{8'h05, 8'h03, 8'h7F, 16'h1000, 16'h1081, 1'b1},
      '{8'h03, 8'h05, 8'h10, 16'h2000, 16'h2002, 1'b0},
      '{8'h80, 8'h01, 8'h80, 16'h3000, 16'h3002, 1'b0},
      '{8'h7F, 8'hFF, 8'h80, 16'h4000, 16'h3F82, 1'b1},
      '{8'h44, 8'h44, 8'hFE, 16'hFFFE, 16'hFFFE, 1'b1},
      '{8'h81, 8'h7F, 8'h05, 16'h5000, 16'h5002, 1'b0}};
   debug_row_t dbg_rows[5] = '{
      '{16'h0100, 16'h0101, 16'h0101, 1'b1, 1'b0, 1'b1},
      '{16'h0501, 16'h0501, 16'h0501, 1'b1, 1'b0, 1'b1},
      '{16'h0203, 16'h0203, 16'h0203, 1'b0, 1'b1, 1'b1},
      '{16'h0300, 16'h0301, 16'h0300, 1'b1, 1'b1, 1'b1},
      '{16'h0400, 16'h0401, 16'h0401, 1'b1, 1'b0, 1'b0}};
   logic        i_clock, i_reset_n, i_instr_valid, i_debug_request;
   logic        i_negative_flag, i_overflow_flag, i_debug_enable;
   logic        i_debug_exit, o_busy, o_program_fetch, o_vector_fetch;
   logic        o_check_read, o_pc_load, o_debug_rom_active;
   logic        o_debug_mode_active, o_done, rom_vec;
   logic [7:0]  i_opcode, i_relative_offset_byte, i_mem_rdata;
   logic [15:0] i_pc, i_vector_data, o_fetch_address, o_new_pc;
   logic [15:0] o_saved_return_pointer, first_addr, last_addr;
   logic [15:0] vec_addr, srp_vec, chk_addr, new_pc;
   int          fails, checks_done, n_fetch, n_vec, n_load, n_done;

   signed_branch_and_debug_entry #(.VECTOR_ADDR(VEC_ADDR)) DUT (.*);
   instr_memory_model #(.VECTOR_VALUE(VEC_VALUE)) memory (
      .i_clock(i_clock), .i_vector_fetch(o_vector_fetch),
      .i_check_read(o_check_read), .i_address(o_fetch_address),
      .o_vector_data(i_vector_data), .o_read_byte(i_mem_rdata));

   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   // ==========================================
   // Log of strobes seen at the ports
   always @(posedge i_clock) begin
      if (o_program_fetch === 1'b1) begin
         if (n_fetch == 0) first_addr = o_fetch_address;
         last_addr = o_fetch_address;
         n_fetch++;
      end
      if (o_vector_fetch === 1'b1) begin
         n_vec++;
         vec_addr = o_fetch_address;
         srp_vec = o_saved_return_pointer;
         rom_vec = o_debug_rom_active;
      end
      if (o_check_read === 1'b1) chk_addr = o_fetch_address;
      if (o_pc_load === 1'b1) begin
         n_load++;
         new_pc = o_new_pc;
      end
      if (o_done === 1'b1) n_done++;
   end
   // ==========================================
   // Helpers
   task automatic step();
      @(posedge i_clock);
      #1;
   endtask
   task automatic clear_log();
      {n_fetch, n_vec, n_load, n_done} = '0;
      {first_addr, last_addr, vec_addr, srp_vec, chk_addr, new_pc} = '0;
      rom_vec = 1'b0;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 20 && n_done == 0; i++) step();
      `CHECK("done pulses", 1, n_done)
   endtask
   function automatic logic [1:0] flags(input logic [7:0] r, m);
      logic [7:0] d;
      d = r - m;
      return {d[7], (r[7] != m[7]) && (d[7] != r[7])};
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge i_clock);
      fails++;
      test_done();
   end
   // ==========================================
   // Main sequence
   initial begin
      {i_instr_valid, i_debug_request, i_debug_exit, i_debug_enable} = '0;
      {i_negative_flag, i_overflow_flag, i_opcode} = '0;
      {i_relative_offset_byte, i_pc} = '0;
      i_reset_n = 1'b0;
      clear_log();
      repeat (8) step();
      `CHECK("mode in reset", 1'b0, o_debug_mode_active)
      `CHECK("busy in reset", 1'b0, o_busy)
      i_reset_n = 1'b1;
      step();
      foreach (br_rows[k]) begin
         clear_log();
         i_opcode = OPC_BRANCH_GE;
         i_relative_offset_byte = br_rows[k].off;
         i_pc = br_rows[k].pc;
         {i_negative_flag, i_overflow_flag} = flags(br_rows[k].r, br_rows[k].m);
         i_instr_valid = 1'b1;
         step();
         i_instr_valid = 1'b0;
         wait_done();
         `CHECK("fetches", br_rows[k].taken ? 3 : 1, n_fetch)
         `CHECK("pc loads", br_rows[k].taken ? 1 : 0, n_load)
         `CHECK("first fetch", br_rows[k].exp_addr, first_addr)
         `CHECK("last fetch", br_rows[k].exp_addr +
                (br_rows[k].taken ? 16'h4 : 16'h0), last_addr)
         if (br_rows[k].taken)
            `CHECK("new pc", br_rows[k].exp_addr, new_pc)
      end
      foreach (dbg_rows[k]) begin
         clear_log();
         i_opcode = OPC_ENTER_DEBUG;
         i_pc = dbg_rows[k].pc;
         i_debug_enable = dbg_rows[k].en;
         i_instr_valid = dbg_rows[k].instr;
         i_debug_request = dbg_rows[k].req;
         step();
         {i_instr_valid, i_debug_request} = 2'h0;
         if (dbg_rows[k].en) begin
            for (int i = 0; i < 20 && !o_debug_mode_active; i++) step();
            `CHECK("active", 1'b1, o_debug_mode_active)
            `CHECK("saved ptr", dbg_rows[k].exp_srp,
                   o_saved_return_pointer)
            // Stray branch while busy must be ignored
            i_opcode = OPC_BRANCH_GE;
            i_instr_valid = 1'b1;
            step();
            i_instr_valid = 1'b0;
            repeat (4) step();
            `CHECK("still active", 1'b1, o_debug_mode_active)
            `CHECK("early loads", 0, n_load)
            `CHECK("busy active", 1'b1, o_busy)
            i_debug_exit = 1'b1;
            step();
            i_debug_exit = 1'b0;
         end
         wait_done();
         `CHECK("vector reads", 1, n_vec)
         `CHECK("vector addr", VEC_ADDR, vec_addr)
         `CHECK("ptr at vector", dbg_rows[k].pc, srp_vec)
         `CHECK("rom at vector", 1'b1, rom_vec)
         `CHECK("check addr", dbg_rows[k].pc, chk_addr)
         `CHECK("first fetch", VEC_VALUE, first_addr)
         `CHECK("fetches", 6, n_fetch)
         `CHECK("pc loads", 1, n_load)
         `CHECK("resume pc", dbg_rows[k].exp_resume, new_pc)
         `CHECK("last fetch", dbg_rows[k].exp_resume + 16'h4,
                last_addr)
         `CHECK("rom off", 1'b0, o_debug_rom_active)
      end
      // Reset in mid debug session
      i_debug_enable = 1'b1;
      i_debug_request = 1'b1;
      step();
      i_debug_request = 1'b0;
      for (int i = 0; i < 20 && !o_debug_mode_active; i++) step();
      i_reset_n = 1'b0;
      repeat (2) step();
      `CHECK("mode after reset", 1'b0, o_debug_mode_active)
      `CHECK("rom after reset", 1'b0, o_debug_rom_active)
      i_reset_n = 1'b1;
      step();
      `CHECK("busy after reset", 1'b0, o_busy)
      // Unknown opcode is ignored
      clear_log();
      i_opcode = 8'h2D;
      i_instr_valid = 1'b1;
      step();
      i_instr_valid = 1'b0;
      repeat (4) step();
      `CHECK("ignored opcode", 0, n_fetch + n_vec + n_done)
      // Debug request wins over a branch in the same cycle
      clear_log();
      i_debug_enable = 1'b0;
      i_opcode = OPC_BRANCH_GE;
      i_pc = 16'h0601;
      {i_instr_valid, i_debug_request} = 2'h3;
      step();
      {i_instr_valid, i_debug_request} = 2'h0;
      wait_done();
      `CHECK("request wins", 1, n_vec)
      `CHECK("request fetches", 6, n_fetch)
      `CHECK("request resume", 16'h0601, new_pc)
      test_done();
   end
endmodule
